// ==== verilog/relay_channel_control_latch.sv ====
// Sixteen-channel relay control latch with command port and readback.
// Assumes the controller drives commands on i_clk; module presence is a pin.
//
// Notes on behaviour
// - Word bit n drives relay channel n; bit 0 is channel 0, bit 15 channel 15.
// - Bit 1 energizes relay (closed, on); bit 0 leaves it de-energized (open).
// - Whole-word write loads all sixteen channel bits in one operation.
// - Whole-word read returns the programmed latch state with the same mapping.
// - Word is unsigned binary; channel 15 is the most significant bit.
// - Single-channel write changes only the addressed channel bit.
// - Close-list sets listed bits to closed, others unchanged.
// - Open-list clears listed bits to open, others unchanged.
// - State query reports latch value of each listed channel.
// - Reset command returns all latches and relays to power-on state.
// - Identity query returns the product identification code.
// - Terminal module absent gives a generic, incomplete identification code.
// - Data crosses as a binary word; decimal conversion is the controller's.
// - With power gone all relays fall to normally-open, the open state.
// - Latch holds each relay state until that channel is reprogrammed.
`timescale 1ns/1ps
`default_nettype none
module relay_channel_control_latch
   import relay_latch_pkg::*;
#(
   parameter logic [23:0] ID_FULL = ID_FULL_DEFAULT,
   parameter logic [23:0] ID_PARTIAL = ID_PARTIAL_DEFAULT
) (
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic i_ce,
   input wire logic i_cmd_valid,
   input wire logic [2:0] i_cmd,
   input wire logic i_id_query,
   input wire logic [15:0] i_wdata,
   input wire logic [3:0] i_chan,
   input wire logic i_chan_data,
   input wire logic i_terminal_present,
   output logic [15:0] o_relay_drive,
   output logic [15:0] o_rdata,
   output logic o_rdata_valid,
   output logic [23:0] o_id,
   output logic o_id_valid
);

   // ------------------------------------------------------------
   // Presence pin synchroniser
   // ------------------------------------------------------------
   logic pres_s1_r, pres_s2_r, pres_s3_r, pres_r;
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         pres_s1_r <= 1'b0;
         pres_s2_r <= 1'b0;
         pres_s3_r <= 1'b0;
         pres_r <= 1'b0;
      end else if (i_ce) begin
         pres_s1_r <= i_terminal_present;
         pres_s2_r <= pres_s1_r;
         pres_s3_r <= pres_s2_r;
         // Accept a change only when two stages agree
         if (pres_s2_r == pres_s3_r) begin
            pres_r <= pres_s3_r;
         end
      end
   end

   // ------------------------------------------------------------
   // Command decode
   // ------------------------------------------------------------
   wire logic go = i_ce && i_cmd_valid;
   wire logic do_word_wr = go && (i_cmd == CMD_WORD_WRITE);
   wire logic do_word_rd = go && (i_cmd == CMD_WORD_READ);
   wire logic do_chan_wr = go && (i_cmd == CMD_CHAN_WRITE);
   wire logic do_close = go && (i_cmd == CMD_CLOSE_LIST);
   wire logic do_open = go && (i_cmd == CMD_OPEN_LIST);
   wire logic do_query = go && (i_cmd == CMD_STATE_QUERY);
   wire logic do_reset = go && (i_cmd == CMD_RESET);
   wire logic do_id = i_ce && i_id_query;

   logic [15:0] latch_r, latch_nxt;
   logic [15:0] chan_mask;
   assign chan_mask = 16'h0001 << i_chan;

   always_comb begin
      latch_nxt = latch_r;
      if (do_reset) begin
         latch_nxt = LATCH_RESET;
      end else if (do_word_wr) begin
         latch_nxt = i_wdata;
      end else if (do_chan_wr) begin
         latch_nxt = i_chan_data ? (latch_r | chan_mask)
                                 : (latch_r & ~chan_mask);
      end else if (do_close) begin
         latch_nxt = latch_r | i_wdata;
      end else if (do_open) begin
         latch_nxt = latch_r & ~i_wdata;
      end
   end

   // ------------------------------------------------------------
   // Latch, readback and identity
   // ------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         latch_r <= LATCH_RESET;
         o_rdata <= LATCH_RESET;
         o_rdata_valid <= 1'b0;
         o_id <= '0;
         o_id_valid <= 1'b0;
      end else if (i_ce) begin
         latch_r <= latch_nxt;
         o_rdata_valid <= do_word_rd || do_query;
         o_id_valid <= do_id;
         if (do_word_rd) begin
            o_rdata <= latch_r;
         end else if (do_query) begin
            o_rdata <= latch_r & i_wdata;
         end
         if (do_id) begin
            o_id <= pres_r ? ID_FULL : ID_PARTIAL;
         end
      end
   end

   // Bit n straight to channel n; all-zero is every relay released
   assign o_relay_drive = latch_r;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rstn);

   chk_word_write_load: assert property (do_word_wr |=> latch_r == $past(i_wdata))
      else $error("word write not loaded");
   chk_reset_clears: assert property (do_reset |=> latch_r == LATCH_RESET)
      else $error("reset command did not clear latch");
   chk_chan_only: assert property (do_chan_wr && !do_reset
         |=> (latch_r & ~$past(chan_mask)) == ($past(latch_r) & ~$past(chan_mask)))
      else $error("single channel write touched other bits");
   chk_chan_value: assert property (do_chan_wr
         |=> latch_r[$past(i_chan)] == $past(i_chan_data))
      else $error("single channel write wrong value");
   chk_close_list: assert property (do_close
         |=> latch_r == ($past(latch_r) | $past(i_wdata)))
      else $error("close list wrong");
   chk_open_list: assert property (do_open
         |=> latch_r == ($past(latch_r) & ~$past(i_wdata)))
      else $error("open list wrong");
   chk_read_back: assert property (do_word_rd
         |=> o_rdata_valid && o_rdata == $past(latch_r))
      else $error("readback mismatch");
   chk_state_query: assert property (do_query
         |=> o_rdata == ($past(latch_r) & $past(i_wdata)))
      else $error("state query mismatch");
   chk_hold_idle: assert property (i_ce && !i_cmd_valid |=> $stable(latch_r))
      else $error("latch changed without command");
   chk_id_answer: assert property (do_id
         |=> o_id_valid && o_id == ($past(pres_r) ? ID_FULL : ID_PARTIAL))
      else $error("identity answer wrong");
   chk_drive_map: assert property (o_relay_drive == latch_r)
      else $error("relay drive not equal to latch");

   // Identity answer in two steps: ask, then a single valid pulse
   sequence seq_id_ask;
      do_id;
   endsequence
   sequence seq_id_pulse;
      o_id_valid ##1 (!o_id_valid || $past(do_id));
   endsequence
   chk_id_pulse: assert property (seq_id_ask |=> seq_id_pulse)
      else $error("identity valid not a single pulse");
   chk_ce_freeze: assert property (!i_ce |=> $stable(latch_r) && $stable(o_rdata))
      else $error("state changed while clock enable low");
   chk_query_valid: assert property (do_query |=> o_rdata_valid)
      else $error("state query not flagged valid");

endmodule : relay_channel_control_latch
`default_nettype wire

// ==== shared/relay_latch_pkg.sv ====
// Package: constants for the sixteen-channel relay control latch.
// Assumes a single 200 MHz backplane clock and a command-strobe port.
package relay_latch_pkg;
   localparam int CHAN_COUNT = 16;
   localparam int CHAN_IDX_W = 4;
   localparam int ID_W = 24;
   localparam int CMD_W = 3;
   localparam logic [15:0] LATCH_RESET = 16'h0000;
   localparam logic CHAN_CLOSED = 1'b1;
   localparam logic CHAN_OPEN = 1'b0;
   // Identity values are arbitrary, not tied to any real part
   localparam logic [23:0] ID_FULL_DEFAULT = 24'hA5C301;
   localparam logic [23:0] ID_PARTIAL_DEFAULT = 24'hA5C000;
   // Command codes on the command port
   localparam logic [2:0] CMD_NOP = 3'h0;
   localparam logic [2:0] CMD_WORD_WRITE = 3'h1;
   localparam logic [2:0] CMD_WORD_READ = 3'h2;
   localparam logic [2:0] CMD_CHAN_WRITE = 3'h3;
   localparam logic [2:0] CMD_CLOSE_LIST = 3'h4;
   localparam logic [2:0] CMD_OPEN_LIST = 3'h5;
   localparam logic [2:0] CMD_STATE_QUERY = 3'h6;
   localparam logic [2:0] CMD_RESET = 3'h7;
   localparam logic [2:0] CMD_ID_QUERY = 3'h0;
endpackage : relay_latch_pkg

// ==== sim/ctl_model.sv ====
// Controller model: drives one command per call onto the command port.
// Assumes a single caller process and the bench clock.
`timescale 1ns/1ps
`default_nettype none
module ctl_model
   import relay_latch_pkg::*;
(
   input wire logic i_clk,
   output logic o_cmd_valid,
   output logic [2:0] o_cmd,
   output logic o_id_query,
   output logic [15:0] o_wdata,
   output logic [3:0] o_chan,
   output logic o_chan_data
);
   initial {o_cmd_valid, o_cmd, o_id_query, o_wdata, o_chan, o_chan_data} = '0;
   task automatic issue(input logic [2:0] c, input logic q, input logic [15:0] w,
                        input logic [3:0] n, input logic d);
      @(posedge i_clk);
      o_cmd_valid <= ~q;
      o_id_query <= q;
      o_cmd <= c;
      o_wdata <= w;
      o_chan <= n;
      o_chan_data <= d;
      @(posedge i_clk);
      o_cmd_valid <= 1'b0;
      o_id_query <= 1'b0;
      // Stale data must not look valid
      o_wdata <= ~w;
   endtask : issue
endmodule : ctl_model
`default_nettype wire

// ==== sim/testbench.sv ====
// Bench: latch driven through the controller model, checked against a reference.
// Assumes 200 MHz clock; answers settle just after the taking edge.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import relay_latch_pkg::*;
   logic i_clk, i_rstn, i_ce, i_terminal_present, i_cmd_valid, i_id_query, i_chan_data;
   logic [2:0] i_cmd;
   logic [15:0] i_wdata, o_relay_drive, o_rdata;
   logic [3:0] i_chan;
   logic o_rdata_valid, o_id_valid;
   logic [23:0] o_id;
   int n_fail = 0, comparisons = 0, ref_w = 0;
   relay_channel_control_latch uut (.i_clk, .i_rstn, .i_ce, .i_cmd_valid, .i_cmd,
      .i_id_query, .i_wdata, .i_chan, .i_chan_data, .i_terminal_present,
      .o_relay_drive, .o_rdata, .o_rdata_valid, .o_id, .o_id_valid);
   ctl_model ctl (.i_clk, .o_cmd_valid(i_cmd_valid), .o_cmd(i_cmd), .o_id_query(i_id_query),
      .o_wdata(i_wdata), .o_chan(i_chan), .o_chan_data(i_chan_data));
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp
   task automatic report_and_stop;
      $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : report_and_stop
   // ------------------------------
   // Command with reference update
   // ------------------------------
   task automatic op(input logic [2:0] c, input logic [15:0] w, input logic [3:0] n,
                     input logic d);
      logic [15:0] old;
      logic rd;
      old = ref_w[15:0];
      rd = (c == CMD_WORD_READ || c == CMD_STATE_QUERY);
      case (c)
         CMD_WORD_WRITE: ref_w = w;
         CMD_CHAN_WRITE: ref_w[n] = d;
         CMD_CLOSE_LIST: ref_w = ref_w | w;
         CMD_OPEN_LIST: ref_w = ref_w & ~w;
         CMD_RESET: ref_w = 0;
         default: ;
      endcase
      ctl.issue(c, 1'b0, w, n, d);
      #1;
      cmp(o_relay_drive, ref_w[15:0]);
      cmp(o_rdata_valid, rd);
      if (rd)
         cmp(o_rdata, (c == CMD_STATE_QUERY) ? (old & w) : old);
   endtask : op
   task automatic idq(input logic p, input logic [23:0] e);
      @(posedge i_clk);
      i_terminal_present <= p;
      repeat (6) @(posedge i_clk);
      ctl.issue(CMD_NOP, 1'b1, 16'h0000, 4'h0, 1'b0);
      #1;
      cmp(o_id_valid, 1'b1);
      cmp(o_id, e);
   endtask : idq
   initial begin
      i_clk = 1'b0;
      forever #2.5 i_clk = ~i_clk;
   end
   initial begin
      i_rstn = 1'b0;
      i_ce = 1'b1;
      i_terminal_present = 1'b1;
      void'($urandom(63410));
      repeat (16) @(posedge i_clk);
      i_rstn <= 1'b1;
      #1;
      cmp(o_relay_drive, 16'h0000);
      cmp(o_id, 24'h000000);
      op(CMD_WORD_WRITE, 16'h0029, 4'h0, 1'b0);
      op(CMD_WORD_READ, 16'h0000, 4'h0, 1'b0);
      op(CMD_WORD_WRITE, 16'hA06A, 4'h0, 1'b0);
      op(CMD_WORD_READ, 16'h0000, 4'h0, 1'b0);
      op(CMD_CHAN_WRITE, 16'h0000, 4'hF, 1'b0);
      op(CMD_CHAN_WRITE, 16'h0000, 4'h3, 1'b1);
      op(CMD_CLOSE_LIST, 16'h0132, 4'h0, 1'b0);
      op(CMD_OPEN_LIST, 16'h2023, 4'h0, 1'b0);
      op(CMD_STATE_QUERY, 16'h00FF, 4'h0, 1'b0);
      op(CMD_NOP, 16'hFFFF, 4'h0, 1'b0);
      for (int k = 0; k < 30; k++)
         op(3'($urandom_range(1, 6)), 16'($urandom), 4'($urandom),
            1'($urandom));
      // Mid-run reset must bring the latch back to all zeros
      @(posedge i_clk);
      i_rstn <= 1'b0;
      @(posedge i_clk);
      i_rstn <= 1'b1;
      ref_w = 0;
      #1;
      cmp(o_relay_drive, 16'h0000);
      @(posedge i_clk);
      i_ce <= 1'b0;
      ctl.issue(CMD_WORD_WRITE, 1'b0, 16'hFFFF, 4'h0, 1'b0);
      #1;
      cmp(o_relay_drive, ref_w[15:0]);
      @(posedge i_clk);
      i_ce <= 1'b1;
      op(CMD_RESET, 16'h0000, 4'h0, 1'b0);
      idq(1'b1, ID_FULL_DEFAULT);
      idq(1'b0, ID_PARTIAL_DEFAULT);
      report_and_stop();
   end
   // Run needs well under 1 us; a hang costs a mismatch
   initial begin
      #5000;
      n_fail++;
      report_and_stop();
   end
endmodule : testbench
`default_nettype wire
